// ---- inc/fbp_pkg.sv ----
/*
 * Package for the full-bridge pwm sequencer: timing constants, phase states
 * and the packed carriers for comparator flags and drive outputs.
 * Assumes a 100 MHz block clock and comparator flags arriving asynchronously.
 */
package fbp_pkg;

   // =========================================================================
   // timing
   // =========================================================================
   localparam int CLK_PERIOD_NS     = 10;
   localparam int MIN_PULSE_NS      = 525;
   localparam int MIN_PULSE_CYC     = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PERIOD_NS         = 5000;
   localparam int PERIOD_CYC        = PERIOD_NS / CLK_PERIOD_NS;
   localparam int CNT_W             = 16;
   localparam int SYNC_STAGES       = 2;
   localparam int SR_ARM_EDGES      = 2;
   localparam int BURST_PAIR_PULSES = 2;
   localparam int BURST_OFF_HALVES  = 4;
   localparam int SS_RAMP_STEP      = 1;

   // =========================================================================
   // reset values
   // =========================================================================
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   localparam logic [1:0]       EDGE_RST = 2'h0;

   // =========================================================================
   // half-cycle phase of the bridge
   // =========================================================================
   typedef enum logic [1:0] {
      FBP_IDLE   = 2'b00,
      FBP_HALF_A = 2'b01,
      FBP_HALF_B = 2'b10,
      FBP_OFF    = 2'b11
   } fbp_phase_t;

   // comparator flags from the analog side, plus the sync input from a master
   typedef struct packed {
      logic uvlo_ok;      // supply above rising threshold
      logic ref_ok;       // reference regulator ready
      logic temp_ok;      // junction below thermal limit
      logic ss_ok;        // soft-start not below its threshold
      logic cs_below_dcm; // current sense below light-load threshold
      logic cur_limit;    // cycle-by-cycle current limit tripped
      logic pwm_end;      // loop comparator says end the pulse
      logic sync_in;      // synchronization from a master
   } fbp_flags_t;

   typedef struct packed {
      logic primary_left_upper_drive;
      logic primary_left_lower_drive;
      logic primary_right_upper_drive;
      logic primary_right_lower_drive;
      logic rectifier_drive_one;
      logic rectifier_drive_two;
   } fbp_drives_t;

   localparam int FLAG_W = $bits(fbp_flags_t);

endpackage : fbp_pkg

// ---- hdl/fbp_sync.sv ----
/*
 * Two-stage synchroniser for a vector of asynchronous comparator flags.
 * Assumes the flags are static for at least two block clocks to be seen.
 */
`timescale 1ns/1ps
module fbp_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             rst_n_i,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   // =========================================================================
   // two flops; the first one is read only by the second
   // =========================================================================
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta   <= '0;
         sync_o <= '0;
      end else begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end

endmodule : fbp_sync

// ---- hdl/fbp_sequencer.sv ----
/*
 * Full-bridge pwm sequencer: start gating, duty priority, light-load modes and
 * rectifier control for a phase-shifted bridge.
 * Assumes analog comparators give flags, gate drivers add dead time outside.
 */
//
// Overview of operation
// - start is raised only while supply, reference, temperature and soft-start level are all good.
// - outside current limit no primary pulse is shorter than the minimum pulse width.
// - a current-limit trip ends the pulse at once, overriding loop demand and minimum width.
// - the loop reference is the lower of soft-start minus offset and the external reference.
// - soft-start held low stops switching; release restarts with a rising duty unless limiting.
// - the internal reference regulator is disabled only during undervoltage lockout.
// - current sense below the light-load threshold enters discontinuous mode with rectifiers low.
// - burst mode emits an even number of minimum pulses then an off interval, repeating.
// - burst entry is decided by the minimum pulse width, not a separate threshold.
// - in burst at start-up no pulse appears on the second rectifier drive.
// - rectifier drives stay off until two primary falling edges have been seen.
// - master drives the sync output; a slave times its cycles from the sync input.
// - voltage or peak-current mode is chosen by the slope-compensation select input.
// - no left-leg primary goes high while both rectifier drives are high.
// - each rectifier drive rises with its paired right-leg primary drive.
`timescale 1ns/1ps
module fbp_sequencer #(
   parameter int PERIOD_CYC    = fbp_pkg::PERIOD_CYC,
   parameter int MIN_PULSE_CYC = fbp_pkg::MIN_PULSE_CYC
) (
   input  wire logic                clk_i,
   input  wire logic                rst_n_i,
   input  wire logic                sync_rst_i,
   input  wire fbp_pkg::fbp_flags_t flags_i,
   input  wire logic                ss_below_ext_ref_i,
   input  wire logic                freq_set_input_i,
   input  wire logic                slope_comp_select_i,
   output fbp_pkg::fbp_drives_t     drives_o,
   output logic                     sync_out_o,
   output logic                     ref_reg_en_o,
   output logic                     loop_ref_from_ss_o,
   output logic                     peak_current_mode_o,
   output logic                     discontinuous_conduction_mode_o,
   output logic                     burst_active_o,
   output logic                     start_o
);

   // =========================================================================
   // input synchronisation
   // =========================================================================
   localparam int CW = fbp_pkg::CNT_W;
   fbp_pkg::fbp_flags_t fl;
   logic [2:0]          cfg_s;

   fbp_sync #(.WIDTH(fbp_pkg::FLAG_W)) u_flag_sync (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .async_i (flags_i),
      .sync_o  (fl)
   );

   fbp_sync #(.WIDTH(3)) u_cfg_sync (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .async_i ({ss_below_ext_ref_i, freq_set_input_i, slope_comp_select_i}),
      .sync_o  (cfg_s)
   );

   // =========================================================================
   // decode
   // =========================================================================
   function automatic logic [CW-1:0] to_cnt(input int v);
      to_cnt = CW'(v);
   endfunction : to_cnt

   wire is_master  = cfg_s[1];
   // start gating; pin below threshold stops switching
   wire next_start = fl.uvlo_ok & fl.ref_ok & fl.temp_ok & fl.ss_ok & ~sync_rst_i;

   logic [CW-1:0] cnt;
   logic [CW-1:0] ss_ramp;
   logic          sync_q;
   logic          start;
   fbp_pkg::fbp_phase_t phase;
   logic          pulse_on;
   logic [1:0]    fall_cnt;
   logic [1:0]    burst_cnt;
   logic [2:0]    off_cnt;
   logic          startup_burst;
   logic          short_seen;

   wire sync_rise = is_master ? 1'b0 : (cfg_s[1] == 1'b0) & fl.sync_in & ~sync_q;
   // at-or-past, so a count left long by slave timing still closes the half
   wire half_end  = is_master ? (cnt >= to_cnt(PERIOD_CYC - 1)) : sync_rise;
   wire at_min    = cnt >= to_cnt(MIN_PULSE_CYC);
   // burst entry from min pulse: loop wants less than the min pulse
   wire loop_short = fl.pwm_end & ~at_min & ~fl.cur_limit;
   // the short request is seen before the minimum ends the pulse, so it is kept
   wire burst_req  = loop_short | short_seen;
   // soft-start ramp forms a duty ceiling while it is the lower reference
   wire ss_limit  = cfg_s[2] & (cnt >= ss_ramp) & at_min;
   // current limit wins; otherwise never below min width
   wire end_pulse = fl.cur_limit | (at_min & (fl.pwm_end | ss_limit));
   wire in_burst  = burst_cnt != 2'h0 || off_cnt != 3'h0;
   wire discontinuous_conduction_mode       = fl.cs_below_dcm;
   // rectifiers armed after two falling edges
   wire sr_armed  = fall_cnt == 2'(fbp_pkg::SR_ARM_EDGES);

   // =========================================================================
   // cycle counter and soft-start ramp
   // =========================================================================
   // master counts its own period; slave restarts on the sync edge
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt     <= fbp_pkg::CNT_RST;
         ss_ramp <= fbp_pkg::CNT_RST;
         sync_q  <= 1'b0;
         start   <= 1'b0;
      end else begin
         sync_q <= fl.sync_in;
         start  <= next_start;
         cnt    <= (!start || half_end) ? fbp_pkg::CNT_RST : cnt + to_cnt(1);
         // gradual restart; ramp only grows while no limit is present
         if (!start)
            ss_ramp <= to_cnt(MIN_PULSE_CYC);
         else if (half_end && !fl.cur_limit && ss_ramp < to_cnt(PERIOD_CYC))
            ss_ramp <= ss_ramp + to_cnt(fbp_pkg::SS_RAMP_STEP);
      end
   end

   // =========================================================================
   // phase, pulse, burst and rectifier arming
   // =========================================================================
   // loss of start clears burst and arming state
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase         <= fbp_pkg::FBP_IDLE;
         pulse_on      <= 1'b0;
         fall_cnt      <= fbp_pkg::EDGE_RST;
         burst_cnt     <= 2'h0;
         off_cnt       <= 3'h0;
         startup_burst <= 1'b0;
         short_seen    <= 1'b0;
      end else if (!start) begin
         phase         <= fbp_pkg::FBP_IDLE;
         pulse_on      <= 1'b0;
         fall_cnt      <= fbp_pkg::EDGE_RST;
         burst_cnt     <= 2'h0;
         off_cnt       <= 3'h0;
         startup_burst <= 1'b1;
         short_seen    <= 1'b0;
      end else begin
         // remember a loop request below the minimum within this pulse
         if (half_end)
            short_seen <= 1'b0;
         else if (pulse_on && loop_short)
            short_seen <= 1'b1;
         if (pulse_on && end_pulse) begin
            pulse_on <= 1'b0;
            if (!sr_armed)
               fall_cnt <= fall_cnt + 2'h1;
            // count minimum pulses in pairs; a finished pair starts the off interval
            if (burst_req || burst_cnt != 2'h0) begin
               if (burst_cnt == 2'(fbp_pkg::BURST_PAIR_PULSES - 1)) begin
                  burst_cnt <= 2'h0;
                  off_cnt   <= 3'(fbp_pkg::BURST_OFF_HALVES);
               end else begin
                  burst_cnt <= burst_cnt + 2'h1;
               end
            end
         end
         if (half_end) begin
            unique case (phase)
               fbp_pkg::FBP_IDLE:   phase <= fbp_pkg::FBP_HALF_A;
               fbp_pkg::FBP_HALF_A: phase <= fbp_pkg::FBP_HALF_B;
               fbp_pkg::FBP_HALF_B: phase <= fbp_pkg::FBP_HALF_A;
               fbp_pkg::FBP_OFF:    phase <= fbp_pkg::FBP_HALF_A;
            endcase
            // off interval: no pulses for a few half cycles
            if (off_cnt != 3'h0) begin
               off_cnt  <= off_cnt - 3'h1;
               pulse_on <= 1'b0;
            end else begin
               pulse_on <= 1'b1;
            end
            if (!in_burst && sr_armed)
               startup_burst <= 1'b0;
         end
      end
   end

   // =========================================================================
   // output drives, all registered
   // =========================================================================
   wire half_a = phase == fbp_pkg::FBP_HALF_A;
   wire half_b = phase == fbp_pkg::FBP_HALF_B;
   wire run    = start & pulse_on & ~(pulse_on & end_pulse);
   // rectifiers follow their right-leg partner; held low in dcm
   wire rect_one = half_a & start & sr_armed & ~discontinuous_conduction_mode;
   // no second rectifier pulse in start-up burst
   wire rect_two = half_b & start & sr_armed & ~discontinuous_conduction_mode & ~(startup_burst & in_burst);
   // left leg blocked while both rectifiers would be high
   wire both_rect = rect_one & rect_two;
   fbp_pkg::fbp_drives_t next_drives;
   assign next_drives.primary_left_upper_drive  = run & half_a & ~both_rect;
   assign next_drives.primary_left_lower_drive  = run & half_b & ~both_rect;
   assign next_drives.primary_right_upper_drive = start & half_a;
   assign next_drives.primary_right_lower_drive = start & half_b;
   assign next_drives.rectifier_drive_one       = rect_one;
   assign next_drives.rectifier_drive_two       = rect_two;

   // synchronous reset clears all drives through start
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         drives_o                        <= '0;
         sync_out_o                      <= 1'b0;
         ref_reg_en_o                    <= 1'b0;
         loop_ref_from_ss_o              <= 1'b0;
         peak_current_mode_o             <= 1'b0;
         discontinuous_conduction_mode_o <= 1'b0;
         burst_active_o                  <= 1'b0;
         start_o                         <= 1'b0;
      end else begin
         drives_o                        <= start ? next_drives : '0;
         // master drives sync at each half-cycle start
         sync_out_o                      <= is_master & start & half_end;
         ref_reg_en_o                    <= fl.uvlo_ok;
         loop_ref_from_ss_o              <= cfg_s[2];
         peak_current_mode_o             <= cfg_s[0];
         discontinuous_conduction_mode_o <= start & discontinuous_conduction_mode;
         burst_active_o                  <= start & in_burst;
         start_o                         <= start;
      end
   end

endmodule : fbp_sequencer

// ---- test/fbp_seq_checker.sv ----
/* port checker for the pwm sequencer.
   assumes one clock domain and a bind that hands on the minimum pulse. */
`timescale 1ns/1ps
module fbp_seq_checker #(
   parameter int MIN_PULSE_CYC = 6
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_n_i,
   input  wire fbp_pkg::fbp_flags_t  flags_i,
   input  wire logic                 freq_set_input_i,
   input  wire logic                 slope_comp_select_i,
   input  wire fbp_pkg::fbp_drives_t drives_o,
   input  wire logic                 sync_out_o,
   input  wire logic                 ref_reg_en_o,
   input  wire logic                 peak_current_mode_o,
   input  wire logic                 discontinuous_conduction_mode_o,
   input  wire logic                 burst_active_o,
   input  wire logic                 start_o
);
   // =====================================
   // helper state
   wire lu = drives_o.primary_left_upper_drive;
   wire ll = drives_o.primary_left_lower_drive;
   wire r1 = drives_o.rectifier_drive_one;
   wire r2 = drives_o.rectifier_drive_two;
   wire ok = flags_i.uvlo_ok & flags_i.ref_ok & flags_i.temp_ok & flags_i.ss_ok;
   logic [15:0] width;  // cycles the left upper drive has stood high
   logic        lim;    // a limit trip was seen in this pulse
   logic [1:0]  falls;  // left-leg falls since start, saturating
   // the limit is remembered for the pulse, since the flag may drop first
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         width <= 16'h0000;
         lim   <= 1'b0;
         falls <= 2'h0;
      end else begin
         width <= lu ? width + 16'h0001 : 16'h0000;
         lim   <= flags_i.cur_limit | (lim & lu);
         if (!start_o) falls <= 2'h0;
         else if (falls != 2'h2 && ($fell(lu) || $fell(ll))) falls <= falls + 2'h1;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // =====================================
   // assertions
   a_idle_no_start: assert property (
      !start_o [*2] |-> drives_o == '0 && !burst_active_o) else $error("drive while stopped");
   a_start_needs_ok: assert property (
      $rose(start_o) |-> $past(ok, 4)) else $error("start without good flags");
   a_start_drops_bad: assert property (
      !ok [*5] |-> !start_o) else $error("start kept with bad flags");
   a_ref_tracks_uvlo: assert property (
      $stable(flags_i.uvlo_ok) [*5] |-> ref_reg_en_o == flags_i.uvlo_ok) else $error("reference enable wrong");
   a_ref_two_flops: assert property (
      $rose(ref_reg_en_o) |-> $past(flags_i.uvlo_ok, 3)) else $error("flag used unsynchronised");
   a_mode_from_cfg: assert property (
      $stable(slope_comp_select_i) [*5] |-> peak_current_mode_o == slope_comp_select_i) else $error("mode wrong");
   a_slave_silent: assert property (
      !freq_set_input_i [*5] |-> !sync_out_o) else $error("slave drives sync");
   a_sync_one_cycle: assert property (
      sync_out_o |=> !sync_out_o) else $error("sync pulse too long");
   a_dcm_rects_low: assert property (
      discontinuous_conduction_mode_o [*2] |-> !r1 && !r2) else $error("rectifier on in dcm");
   a_left_vs_rects: assert property (
      (lu || ll) |-> !(r1 && r2)) else $error("left leg with both rectifiers");
   a_rect_pairing: assert property (
      ($rose(r1) -> drives_o.primary_right_upper_drive) && ($rose(r2) -> drives_o.primary_right_lower_drive))
      else $error("rectifier rose unpaired");
   a_rect_armed: assert property (
      (r1 || r2) |-> falls == 2'h2) else $error("rectifier before two falls");
   a_min_width: assert property (
      $fell(lu) && start_o && !lim |-> width >= MIN_PULSE_CYC) else $error("pulse below minimum");
   c_limited: cover property ($fell(lu) && lim);
   c_burst: cover property (burst_active_o);
   c_dcm: cover property (discontinuous_conduction_mode_o && start_o);
endmodule : fbp_seq_checker

bind fbp_sequencer fbp_seq_checker #(.MIN_PULSE_CYC(MIN_PULSE_CYC)) fbp_seq_checker_inst (.*);

// ---- test/fbp_analog_model.sv ----
/* behavioural comparators facing the sequencer.
   assumes the bench sets health levels, loop demand and limit point. */
`timescale 1ns/1ps
module fbp_analog_model (
   input  wire logic                 clk_i,
   input  wire logic                 rst_n_i,
   input  wire fbp_pkg::fbp_drives_t drives_i,
   input  wire logic [3:0]           health_i,  // supply, reference, thermal, soft-start
   input  wire logic                 cs_low_i,
   input  wire logic [7:0]           demand_i,  // loop pulse length in cycles
   input  wire logic [7:0]           limit_i,   // limit trip point, zero for never
   input  wire logic                 sync_en_i,
   output fbp_pkg::fbp_flags_t       flags_o
);
   // =====================================
   // pulse timing
   logic [7:0] t;  // cycles into the current primary pulse
   logic [5:0] s;  // master spacing for the sync train
   wire on = drives_i.primary_left_upper_drive | drives_i.primary_left_lower_drive;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         t <= 8'h00;
         s <= 6'h00;
      end else begin
         t <= on ? t + 8'h01 : 8'h00;
         s <= s + 6'h01;
      end
   end
   assign flags_o = {health_i, cs_low_i, (limit_i != 8'h00) && on && t >= limit_i, on && t >= demand_i,
                     sync_en_i && s == 6'h00};
endmodule : fbp_analog_model

// ---- test/full_bridge_pwm_sequencer_tb.sv ----
/* self-checking bench for the pwm sequencer.
   assumes the checker is bound and shortened period parameters. */
`timescale 1ns/1ps
module full_bridge_pwm_sequencer_tb;
   localparam int P = 40;
   localparam int M = 6;
   logic                 clk = 1'b0;
   logic                 rst_n = 1'b0;
   logic                 srst = 1'b0;
   logic [3:0]           health = 4'he;  // soft-start still low
   logic                 cs_low = 1'b0;
   logic [7:0]           demand = 8'h1e;
   logic [7:0]           limit = 8'h00;
   logic                 ss_below = 1'b0;
   logic                 fset = 1'b1;
   logic                 slope = 1'b0;
   fbp_pkg::fbp_flags_t  flags;
   fbp_pkg::fbp_drives_t drv;
   logic                 sync_out, refen, lref, pcm, discontinuous_conduction_mode, burst, start;
   int                   n_fail = 0;
   int                   tests_run = 0;
   fbp_sequencer #(.PERIOD_CYC(P), .MIN_PULSE_CYC(M)) fbp_sequencer_inst (.clk_i(clk), .rst_n_i(rst_n),
      .sync_rst_i(srst), .flags_i(flags), .ss_below_ext_ref_i(ss_below), .freq_set_input_i(fset),
      .slope_comp_select_i(slope), .drives_o(drv), .sync_out_o(sync_out), .ref_reg_en_o(refen),
      .loop_ref_from_ss_o(lref), .peak_current_mode_o(pcm), .discontinuous_conduction_mode_o(discontinuous_conduction_mode),
      .burst_active_o(burst), .start_o(start));
   fbp_analog_model fbp_analog_model_inst (.clk_i(clk), .rst_n_i(rst_n), .drives_i(drv), .health_i(health),
      .cs_low_i(cs_low), .demand_i(demand), .limit_i(limit), .sync_en_i(!fset), .flags_o(flags));
   initial begin
      forever #5 clk = ~clk;
   end
   // =====================================
   // shared tasks
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : report_and_stop
   // start needs four edges after flags, so a short bound suffices
   task automatic wait_start();
      for (int i = 0; i < 50 && start !== 1'b1; i++) @(negedge clk);
      if (start !== 1'b1) report_and_stop();
      chk(start, 1);
   endtask : wait_start
   // width of the next whole left upper pulse
   task automatic pulse_w(output logic [15:0] w);
      w = 16'h0000;
      for (int i = 0; i < 400 && drv.primary_left_upper_drive; i++) @(negedge clk);
      for (int i = 0; i < 400 && !drv.primary_left_upper_drive; i++) @(negedge clk);
      for (int i = 0; i < 400 && drv.primary_left_upper_drive; i++) begin
         @(negedge clk);
         w = w + 16'h0001;
      end
      if (w == 16'h0000) begin
         chk(w, 16'h0001);
         report_and_stop();
      end
   endtask : pulse_w
   // =====================================
   // scenarios
   task automatic t_startup();
      repeat (10) @(negedge clk);
      chk({refen, start, drv}, 16'h0080);
      health = 4'hf;
      wait_start();
   endtask : t_startup
   task automatic t_ss_restart();
      logic [15:0] a, b;
      logic [1:0]  p;
      int          f;
      health = 4'he;
      ss_below = 1'b1;  // soft-start is the lower reference while it ramps
      repeat (8) @(negedge clk);
      chk({start, drv}, 0);
      health = 4'hf;
      wait_start();
      f = 0;
      p = 2'h0;
      for (int i = 0; i < 400 && !(drv.rectifier_drive_one | drv.rectifier_drive_two); i++) begin
         @(negedge clk);
         f += $countones(p & ~drv[5:4]);
         p = drv[5:4];
      end
      chk(drv[1:0] != 2'h0, 1);
      if (drv[1:0] == 2'h0) report_and_stop();
      chk(f >= 2, 1);
      pulse_w(a);
      pulse_w(b);
      chk({a < 16'd30, b > a}, 2'h3);
      ss_below = 1'b0;
   endtask : t_ss_restart
   task automatic t_limit_and_min();
      logic [15:0] w;
      limit = 8'h01;
      pulse_w(w);
      chk(w < M, 1);
      limit = 8'h00;
      demand = 8'h01;
      pulse_w(w);
      chk(w >= M, 1);
      for (int i = 0; i < 400 && burst !== 1'b1; i++) @(negedge clk);
      chk(burst, 1);
      if (burst !== 1'b1) report_and_stop();
      demand = 8'h1e;
   endtask : t_limit_and_min
   task automatic t_dcm();
      logic acc;
      cs_low = 1'b1;
      repeat (6) @(negedge clk);
      acc = 1'b0;
      for (int i = 0; i < 100; i++) begin
         @(negedge clk);
         acc |= drv.rectifier_drive_one | drv.rectifier_drive_two;
      end
      chk({discontinuous_conduction_mode, acc}, 2'h2);
      cs_low = 1'b0;
   endtask : t_dcm
   // every combination of the three configuration levels
   task automatic t_config();
      logic acc;
      for (int k = 0; k < 8; k++) begin
         {ss_below, fset, slope} = k[2:0];
         repeat (6) @(negedge clk);
         chk({lref, pcm}, {ss_below, slope});
         acc = 1'b0;
         for (int i = 0; i < 2 * P; i++) begin
            @(negedge clk);
            acc |= sync_out;
         end
         chk(acc, fset);
      end
   endtask : t_config
   task automatic t_resets();
      srst = 1'b1;
      // start drops one edge after the request, its output copy one edge later
      repeat (2) @(negedge clk);
      chk(start, 0);
      chk({drv, burst}, 0);
      srst = 1'b0;
      wait_start();
      health = 4'h7;
      repeat (6) @(negedge clk);
      chk({refen, start, drv}, 0);
      health = 4'hf;
      wait_start();
      chk(refen, 1);
   endtask : t_resets
   initial begin
      repeat (12) @(negedge clk);
      rst_n = 1'b1;
      t_startup();
      t_ss_restart();
      t_limit_and_min();
      t_dcm();
      t_config();
      t_resets();
      report_and_stop();
   end
endmodule : full_bridge_pwm_sequencer_tb
